/* design/otg_pkg.sv */
/*
 * Constants shared by the on-the-go control register file: register
 * offsets, reset values, write masks, field positions, link states, timing.
 * Assumes a 250 MHz system clock and an I2C-style serial link.
 */
package otg_pkg;

	// Serial slave address, upper six bits
	localparam logic [5:0] SLV_ADDR_HI  = 6'h16;
	localparam logic [3:0] BIT_LAST     = 4'h8;

	// Register offsets
	localparam logic [7:0] OFS_ID_LAST  = 8'h07;
	localparam logic [7:0] OFS_MAKER_HI = 8'h03;
	localparam logic [7:0] OFS_CTRL1    = 8'h10;
	localparam logic [7:0] OFS_CTRL2    = 8'h11;
	localparam logic [7:0] OFS_STATUS   = 8'h13;
	localparam logic [7:0] OFS_MASK     = 8'h14;
	localparam logic [7:0] OFS_EDGE     = 8'h15;
	localparam logic [7:0] OFS_LATCH    = 8'h16;

	// Values after reset
	localparam logic [7:0] RST_CTRL1    = 8'h00;
	localparam logic [7:0] RST_CTRL2    = 8'h01;
	localparam logic [7:0] RST_IRQ      = 8'h00;

	// Implemented bits; the rest read as zero
	localparam logic [7:0] WMASK_CTRL1  = 8'hf6;
	localparam logic [7:0] WMASK_CTRL2  = 8'h1f;
	localparam logic [7:0] WMASK_MASK   = 8'h3f;
	localparam logic [7:0] WMASK_EDGE   = 8'h03;
	localparam logic [6:0] STATUS_ZERO  = 7'h00;

	// Field positions, first control register
	localparam int CTL1_IRQ_PP = 1;
	localparam int CTL1_POS_HI = 4;
	localparam int CTL1_NEG_HI = 5;
	localparam int CTL1_POS_LO = 6;
	localparam int CTL1_NEG_LO = 7;
	localparam int CTL1_HNP_EN = 2;

	// Field positions, second control register
	localparam int CTL2_PWRDN  = 0;
	localparam int CTL2_TIMED  = 1;
	localparam int CTL2_MANUAL = 2;
	localparam int CTL2_PUMP   = 3;
	localparam int CTL2_BLEED  = 4;

	// Timed charge pulse
	localparam int CHG_PULSE_MS  = 105;
	localparam int MCLK_KHZ      = 250000;
	localparam int CHG_PULSE_CYC = CHG_PULSE_MS * MCLK_KHZ;

	typedef enum logic [2:0] {
		LNK_IDLE  = 3'b000,
		LNK_ADDR  = 3'b001,
		LNK_REG   = 3'b010,
		LNK_WDATA = 3'b011,
		LNK_RDATA = 3'b100
	} otg_link_state_type;

endpackage

/* design/otg_regfile.sv */
/*
 * Control register file of the on-the-go companion, with its serial slave.
 * The serial side runs on scl; the registers and outputs run on mclk.
 * Assumes an open-drain resolver outside for sda and the interrupt pin.
 */
// Notes on behaviour
// - Answer slave address with upper bits 010110; last bit low writes, high reads.
// - Lowest slave address bit follows the address strap pin.
// - Interrupt mask is read/write and enables each interrupt source.
// - Interrupt edge is read/write, choosing rising or falling edge for the two lowest sources; the others use rising edges.
// - Interrupt latch is read-only and reports captured requests.
// - Maker and part code bytes are read-only constants.
// - Second control bit 0 selects shutdown; register resets to 01.
// - First control bit 1 picks open-drain or push-pull interrupt; resets zero.
// - First control bit 4 connects positive pull-up, over negative pull-up.
// - First control bits 5, 6, 7 connect negative pull-up and both pull-downs.
// - Second control bit 1 starts charge current, stopped after 105 ms.
// - Second control bit 2 holds charge current on while set.
// - Second control bit 3 connects the supply line to the charge pump.
// - Second control bit 4 connects the supply-line discharge resistor.
`timescale 1ns/100ps

module otg_regfile
	import otg_pkg::*;
#(
	parameter int            CHG_CYC    = CHG_PULSE_CYC,
	parameter logic [31:0]   MAKER_CODE = 32'hc1d2_e3f4,                          // Arbitrary identity values
	parameter logic [31:0]   PART_CODE  = 32'h9a8b_7c6d
) (
	// System
	input  wire logic mclk,
	input  wire logic sys_rst,
	input  wire logic clk_en,
	// Serial link
	input  wire logic scl,
	input  wire logic sda_in,
	output logic      sda_out,
	output logic      sda_oe_n,
	input  wire logic addr_strap,
	// Comparator and detector levels
	input  wire logic vbus_valid_in,
	input  wire logic sess_valid_in,
	input  wire logic sess_end_in,
	input  wire logic id_gnd_in,
	input  wire logic id_float_in,
	input  wire logic a_hnp_in,
	input  wire logic b_hnp_in,
	// Interrupt pin
	output logic      irq_n_out,
	output logic      irq_oe_n,
	// Analog controls
	output logic      pos_line_pull_high,
	output logic      neg_line_pull_high,
	output logic      pos_line_pull_low,
	output logic      neg_line_pull_low,
	output logic      hnp_connect_en,
	output logic      power_down_ctl,
	output logic      charge_src_on,
	output logic      pump_drive,
	output logic      bleed_discharge
);

	// Each mask bit enables its latch bits
	function automatic logic [7:0] irq_en_map(input logic [7:0] m);
		irq_en_map = {m[5], m[4], m[3], m[2], m[1], m[0], m[1], m[0]};
	endfunction

	function automatic logic addr_match(input logic [7:0] b, input logic a0);
		addr_match = (b[7:1] == {SLV_ADDR_HI, a0});
	endfunction

	// ---------------- Link domain ----------------
	logic               lrst_reg;
	logic               start_tgl_reg;
	logic               start_seen_reg;
	otg_link_state_type lstate_reg;
	logic [3:0]         cnt_reg;
	logic [7:0]         shift_reg;
	logic [7:0]         reg_addr_reg;
	logic [7:0]         wr_data_reg;
	logic               wr_tgl_reg;
	logic               rd_tgl_reg;
	logic [7:0]         rd_byte_reg;
	logic               sda_oe_n_reg;
	logic               sda_out_reg;
	logic               start_now;
	// Both held still by the far side while the link samples them
	logic               a0_reg;
	logic [7:0]         rd_data_reg;

	// Link flops reset from a registered copy of the system reset
	always_ff @(posedge mclk) begin
		lrst_reg <= sys_rst;
	end

	// Start seen as sda falling while scl high
	always_ff @(negedge sda_in or posedge lrst_reg) begin
		if (lrst_reg) begin
			start_tgl_reg <= 1'h0;
		end else if (scl) begin
			start_tgl_reg <= ~start_tgl_reg;
		end
	end

	assign start_now = start_tgl_reg ^ start_seen_reg;

	// Stop needs no logic: every access opens with a start
	always_ff @(posedge scl or posedge lrst_reg) begin
		if (lrst_reg) begin
			start_seen_reg <= 1'h0;
			lstate_reg     <= LNK_IDLE;
			cnt_reg        <= 4'h0;
			shift_reg      <= 8'h00;
			reg_addr_reg   <= 8'h00;
			wr_data_reg    <= 8'h00;
			wr_tgl_reg     <= 1'h0;
			rd_tgl_reg     <= 1'h0;
			rd_byte_reg    <= 8'h00;
		end else if (start_now) begin
			start_seen_reg <= start_tgl_reg;
			lstate_reg     <= LNK_ADDR;
			cnt_reg        <= 4'h1;
			shift_reg      <= {7'h00, sda_in};
		end else if (cnt_reg != BIT_LAST) begin
			shift_reg <= {shift_reg[6:0], sda_in};
			cnt_reg   <= cnt_reg + 4'h1;
		end else begin
			cnt_reg <= 4'h0;
			case (lstate_reg)
				LNK_ADDR: begin
					if (addr_match(shift_reg, a0_reg)) begin
						lstate_reg <= shift_reg[0] ? LNK_RDATA : LNK_REG;
						if (shift_reg[0]) begin
							// Byte frozen here so the clear below matches what is sent
							rd_byte_reg <= rd_data_reg;
							rd_tgl_reg  <= ~rd_tgl_reg;
						end
					end else begin
						lstate_reg <= LNK_IDLE;
					end
				end
				LNK_REG: begin
					reg_addr_reg <= shift_reg;
					lstate_reg   <= LNK_WDATA;
				end
				LNK_WDATA: begin
					wr_data_reg <= shift_reg;
					wr_tgl_reg  <= ~wr_tgl_reg;
					lstate_reg  <= LNK_IDLE;
				end
				LNK_RDATA: lstate_reg <= LNK_IDLE;
				default:   lstate_reg <= LNK_IDLE;
			endcase
		end
	end

	// Sda changes only while scl is low
	always_ff @(negedge scl or posedge lrst_reg) begin
		if (lrst_reg) begin
			sda_oe_n_reg <= 1'h1;
			sda_out_reg  <= 1'h0;
		end else if (start_now) begin
			sda_oe_n_reg <= 1'h1;
		end else if (cnt_reg == BIT_LAST) begin
			sda_oe_n_reg <= ~((lstate_reg == LNK_ADDR && addr_match(shift_reg, a0_reg)) ||
				lstate_reg == LNK_REG || lstate_reg == LNK_WDATA);
		end else if (lstate_reg == LNK_RDATA) begin
			sda_oe_n_reg <= rd_byte_reg[3'(4'h7 - cnt_reg)];
		end else begin
			sda_oe_n_reg <= 1'h1;
		end
	end

	assign sda_out  = sda_out_reg;
	assign sda_oe_n = sda_oe_n_reg;

	// ---------------- System domain ----------------
	logic [6:0] stat_s1_reg;
	logic [6:0] stat_s2_reg;
	logic [6:0] stat_prev_reg;
	logic [3:0] wr_sync_reg;
	logic [3:0] rd_sync_reg;
	logic [1:0] strap_sync_reg;
	logic [7:0] addr_s1_reg;
	logic [7:0] addr_s2_reg;
	logic [7:0] data_s1_reg;
	logic [7:0] data_s2_reg;
	logic [7:0] clr_s1_reg;
	logic [7:0] clr_s2_reg;
	logic [7:0] ctrl1_reg;
	logic [7:0] ctrl2_reg;
	logic [7:0] mask_reg;
	logic [7:0] edge_reg;
	logic [7:0] latch_reg;
	logic [7:0] latch_next;
	logic [7:0] sets;
	logic [7:0] rd_next;
	logic [24:0] chg_cnt_reg;
	logic       timer_on_reg;
	logic       timed_prev_reg;
	logic       wr_evt;
	logic       rd_evt;
	logic       pend;
	logic       irq_n_out_reg;
	logic       irq_oe_n_reg;
	logic [8:0] ctl_out_reg;
	logic [6:0] rise;
	logic [6:0] fall;

	// Pins and link words pass two flops; word sources hold still around their toggle
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			stat_s1_reg    <= 7'h00;
			stat_s2_reg    <= 7'h00;
			strap_sync_reg <= 2'h0;
			wr_sync_reg    <= 4'h0;
			rd_sync_reg    <= 4'h0;
			addr_s1_reg    <= 8'h00;
			addr_s2_reg    <= 8'h00;
			data_s1_reg    <= 8'h00;
			data_s2_reg    <= 8'h00;
			clr_s1_reg     <= 8'h00;
			clr_s2_reg     <= 8'h00;
		end else if (clk_en) begin
			stat_s1_reg    <= {b_hnp_in, a_hnp_in, id_float_in, id_gnd_in, sess_end_in, sess_valid_in,
				vbus_valid_in};
			stat_s2_reg    <= stat_s1_reg;
			strap_sync_reg <= {strap_sync_reg[0], addr_strap};
			wr_sync_reg    <= {wr_sync_reg[2:0], wr_tgl_reg};
			rd_sync_reg    <= {rd_sync_reg[2:0], rd_tgl_reg};
			addr_s1_reg    <= reg_addr_reg;
			addr_s2_reg    <= addr_s1_reg;
			data_s1_reg    <= wr_data_reg;
			data_s2_reg    <= data_s1_reg;
			clr_s1_reg     <= rd_byte_reg;
			clr_s2_reg     <= clr_s1_reg;
		end
	end

	// Event one stage late: the word copies may have caught the old word at the toggle edge
	assign wr_evt = wr_sync_reg[3] ^ wr_sync_reg[2];
	assign rd_evt = rd_sync_reg[3] ^ rd_sync_reg[2];

	// Strap tracked after release; a floating pin is pulled low outside
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			a0_reg <= 1'h0;
		end else if (clk_en) begin
			a0_reg <= strap_sync_reg[1];
		end
	end

	// Register writes; unimplemented bits and addresses drop the data
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ctrl1_reg <= RST_CTRL1;
			ctrl2_reg <= RST_CTRL2;
			mask_reg  <= RST_IRQ;
			edge_reg  <= RST_IRQ;
		end else if (clk_en && wr_evt) begin
			case (addr_s2_reg)
				OFS_CTRL1: ctrl1_reg <= data_s2_reg & WMASK_CTRL1;
				OFS_CTRL2: ctrl2_reg <= data_s2_reg & WMASK_CTRL2;
				OFS_MASK:  mask_reg  <= data_s2_reg & WMASK_MASK;
				OFS_EDGE:  edge_reg  <= data_s2_reg & WMASK_EDGE;
				default:   ctrl1_reg <= ctrl1_reg;
			endcase
		end
	end

	// Interrupt requests from level edges
	assign rise = stat_s2_reg & ~stat_prev_reg;
	assign fall = ~stat_s2_reg & stat_prev_reg;
	assign sets = {rise[5], rise[4], rise[3], rise[2], fall[1] & ~edge_reg[1], fall[0] & ~edge_reg[0],
		rise[1] & edge_reg[1], rise[0] & edge_reg[0]};

	// Cleared by reading it; a request arriving with the clear still lands
	always_comb begin
		latch_next = latch_reg;
		if (rd_evt && addr_s2_reg == OFS_LATCH) begin
			latch_next = latch_reg & ~clr_s2_reg;
		end
		latch_next = latch_next | sets;
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			stat_prev_reg <= 7'h00;
			latch_reg     <= RST_IRQ;
		end else if (clk_en) begin
			stat_prev_reg <= stat_s2_reg;
			latch_reg     <= latch_next;
		end
	end

	// Read mux, held for the link to sample at the address acknowledge
	always_comb begin
		rd_next = 8'h00;
		if (addr_s2_reg <= OFS_MAKER_HI) begin
			rd_next = MAKER_CODE[8 * addr_s2_reg[1:0] +: 8];
		end else if (addr_s2_reg <= OFS_ID_LAST) begin
			rd_next = PART_CODE[8 * addr_s2_reg[1:0] +: 8];
		end else begin
			case (addr_s2_reg)
				OFS_CTRL1:  rd_next = ctrl1_reg;
				OFS_CTRL2:  rd_next = ctrl2_reg;
				OFS_STATUS: rd_next = {1'h0, stat_s2_reg};
				OFS_MASK:   rd_next = mask_reg;
				OFS_EDGE:   rd_next = edge_reg;
				OFS_LATCH:  rd_next = latch_reg;
				default:    rd_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			rd_data_reg <= 8'h00;
		end else if (clk_en) begin
			rd_data_reg <= rd_next;
		end
	end

	// Timed charge pulse, rearmed only by a fresh rising edge of its bit
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			timed_prev_reg <= 1'h0;
			timer_on_reg   <= 1'h0;
			chg_cnt_reg    <= 25'h000_0000;
		end else if (clk_en) begin
			timed_prev_reg <= ctrl2_reg[CTL2_TIMED];
			if (!ctrl2_reg[CTL2_TIMED]) begin
				timer_on_reg <= 1'h0;
			end else if (!timed_prev_reg) begin
				timer_on_reg <= 1'h1;
				chg_cnt_reg  <= 25'(CHG_CYC - 1);
			end else if (timer_on_reg) begin
				if (chg_cnt_reg == 25'h000_0000) begin
					timer_on_reg <= 1'h0;
				end else begin
					chg_cnt_reg <= chg_cnt_reg - 25'h000_0001;
				end
			end
		end
	end

	// Output flops
	assign pend = |(latch_reg & irq_en_map(mask_reg));

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			irq_n_out_reg <= 1'h0;
			irq_oe_n_reg  <= 1'h1;
			ctl_out_reg   <= 9'h001;
		end else if (clk_en) begin
			irq_n_out_reg  <= ctrl1_reg[CTL1_IRQ_PP] & ~pend;
			irq_oe_n_reg   <= ~ctrl1_reg[CTL1_IRQ_PP] & ~pend;
			ctl_out_reg[0] <= ctrl2_reg[CTL2_PWRDN];
			// Current source is dead in shutdown anyway; gate it to be explicit
			ctl_out_reg[1] <= ~ctrl2_reg[CTL2_PWRDN] &
				(ctrl2_reg[CTL2_MANUAL] | timer_on_reg);
			ctl_out_reg[2] <= ctrl2_reg[CTL2_PUMP];
			ctl_out_reg[3] <= ctrl2_reg[CTL2_BLEED];
			ctl_out_reg[4] <= ctrl1_reg[CTL1_POS_HI];
			// Never both pull-ups: avoids tying the data lines together
			ctl_out_reg[5] <= ctrl1_reg[CTL1_NEG_HI] & ~ctrl1_reg[CTL1_POS_HI];
			ctl_out_reg[6] <= ctrl1_reg[CTL1_POS_LO];
			ctl_out_reg[7] <= ctrl1_reg[CTL1_NEG_LO];
			ctl_out_reg[8] <= ctrl1_reg[CTL1_HNP_EN];
		end
	end

	assign irq_n_out          = irq_n_out_reg;
	assign irq_oe_n           = irq_oe_n_reg;
	assign power_down_ctl     = ctl_out_reg[0];
	assign charge_src_on      = ctl_out_reg[1];
	assign pump_drive         = ctl_out_reg[2];
	assign bleed_discharge    = ctl_out_reg[3];
	assign pos_line_pull_high = ctl_out_reg[4];
	assign neg_line_pull_high = ctl_out_reg[5];
	assign pos_line_pull_low  = ctl_out_reg[6];
	assign neg_line_pull_low  = ctl_out_reg[7];
	assign hnp_connect_en     = ctl_out_reg[8];

	// ---------------- Checks ----------------
	property p_addr_ack;
		@(negedge scl) disable iff (lrst_reg)
		(!start_now && cnt_reg == BIT_LAST && lstate_reg == LNK_ADDR) |=>
			(sda_oe_n == ~$past(addr_match(shift_reg, a0_reg)));
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("Slave address acknowledge wrong");

	property p_strap;
		@(posedge mclk) disable iff (sys_rst)
		clk_en ##1 clk_en ##1 clk_en |=> a0_reg == $past(addr_strap, 3);
	endproperty
	a_strap: assert property (p_strap) else $error("Address bit does not follow strap");

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	sequence s_wr(logic [7:0] ofs);
		clk_en && wr_evt && addr_s2_reg == ofs;
	endsequence

	property p_mask_wr;
		s_wr(OFS_MASK) |=> mask_reg == ($past(data_s2_reg) & WMASK_MASK);
	endproperty
	a_mask_wr: assert property (p_mask_wr) else $error("Mask write lost");

	property p_edge_wr;
		s_wr(OFS_EDGE) |=> edge_reg == ($past(data_s2_reg) & WMASK_EDGE);
	endproperty
	a_edge_wr: assert property (p_edge_wr) else $error("Edge write lost");

	property p_latch_ro;
		clk_en && sets == 8'h00 |=> (latch_reg & ~$past(latch_reg)) == 8'h00;
	endproperty
	a_latch_ro: assert property (p_latch_ro) else $error("Latch bit set without request");

	localparam logic [63:0] ID_BYTES = {PART_CODE, MAKER_CODE};

	property p_id_read;
		clk_en && addr_s2_reg <= OFS_ID_LAST |=> rd_data_reg == $past(ID_BYTES[8 * addr_s2_reg[2:0] +: 8]);
	endproperty
	a_id_read: assert property (p_id_read) else $error("Code byte read wrong");

	property p_shutdown;
		clk_en && ctrl2_reg[CTL2_PWRDN] |=> power_down_ctl && !charge_src_on;
	endproperty
	a_shutdown: assert property (p_shutdown) else $error("Shutdown not applied");

	property p_irq_mode;
		clk_en && !ctrl1_reg[CTL1_IRQ_PP] |=> !irq_n_out;
	endproperty
	a_irq_mode: assert property (p_irq_mode) else $error("Open-drain pin driven high");

	property p_pull_prio;
		pos_line_pull_high |-> !neg_line_pull_high;
	endproperty
	a_pull_prio: assert property (p_pull_prio) else $error("Both pull-ups connected");

	property p_pulls;
		clk_en |=> pos_line_pull_low == $past(ctrl1_reg[CTL1_POS_LO]) &&
			neg_line_pull_low == $past(ctrl1_reg[CTL1_NEG_LO]);
	endproperty
	a_pulls: assert property (p_pulls) else $error("Pull-down follows wrong bit");

	sequence s_chg_arm;
		clk_en && ctrl2_reg[CTL2_TIMED] && !timed_prev_reg;
	endsequence

	property p_chg_arm;
		s_chg_arm |=> timer_on_reg && chg_cnt_reg == 25'(CHG_CYC - 1);
	endproperty
	a_chg_arm: assert property (p_chg_arm) else $error("Charge timer not armed");

	property p_chg_end;
		clk_en && timer_on_reg && timed_prev_reg && chg_cnt_reg == 25'h000_0000 |=> !timer_on_reg;
	endproperty
	a_chg_end: assert property (p_chg_end) else $error("Charge timer overran");

	property p_manual;
		clk_en && ctrl2_reg[CTL2_MANUAL] && !ctrl2_reg[CTL2_PWRDN] |=> charge_src_on;
	endproperty
	a_manual: assert property (p_manual) else $error("Manual charge not on");

	property p_pump;
		clk_en |=> pump_drive == $past(ctrl2_reg[CTL2_PUMP]);
	endproperty
	a_pump: assert property (p_pump) else $error("Pump drive mismatch");

	property p_bleed;
		clk_en |=> bleed_discharge == $past(ctrl2_reg[CTL2_BLEED]);
	endproperty
	a_bleed: assert property (p_bleed) else $error("Discharge mismatch");

	property p_reserved;
		clk_en && (addr_s2_reg > OFS_LATCH || (addr_s2_reg > OFS_ID_LAST && addr_s2_reg < OFS_CTRL1) ||
			addr_s2_reg == 8'h12) |=> rd_data_reg == 8'h00;
	endproperty
	a_reserved: assert property (p_reserved) else $error("Reserved address not zero");

	property p_irq;
		clk_en && |(latch_reg & irq_en_map(mask_reg)) |=> (irq_n_out == 1'h0) && (irq_oe_n == 1'h0);
	endproperty
	a_irq: assert property (p_irq) else $error("Interrupt pin not asserted");

endmodule

/* verif/otg_i2c_master.sv */
/* Bus master model for the control register file's serial slave.
   Assumes a pull-up on sda; scl idles high between frames. */
`timescale 1ns/100ps

module otg_i2c_master (
	// Link wires
	output logic      scl,
	output logic      sda_in,
	input  wire logic sda_oe_n
);
	logic sda_m;

	// Open-drain wire, pulled high when nobody pulls low
	assign sda_in = sda_m & sda_oe_n;

	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end

	// Start or repeated start; sda falls while scl is high
	task automatic start_c;
		sda_m = 1'b1;
		#16;
		scl = 1'b1;
		#16;
		sda_m = 1'b0;
		#16;
		scl = 1'b0;
		#16;
	endtask

	task automatic stop_c;
		sda_m = 1'b0;
		#16;
		scl = 1'b1;
		#16;
		sda_m = 1'b1;
		#16;
	endtask

	// Nine clocks, MSB first; ninth released, so a read ends in a nack
	task automatic xbyte(input logic [7:0] d, output logic [7:0] q, output logic nak);
		for (int i = 8; i >= 0; i--) begin
			sda_m = (i == 0) ? 1'b1 : d[i - 1];
			#16;
			scl = 1'b1;
			#16;
			if (i > 0)
				q[i - 1] = sda_in;
			else
				nak = sda_in;
			#16;
			scl = 1'b0;
			#16;
		end
	endtask

	// Odd offset keeps scl unrelated in phase to mclk
	task automatic wr(input logic [6:0] sa, input logic [7:0] ra, input logic [7:0] wd, output logic ok);
		logic [7:0] q;
		logic [2:0] n;
		#1.3;
		start_c;
		xbyte({sa, 1'b0}, q, n[0]);
		xbyte(ra, q, n[1]);
		xbyte(wd, q, n[2]);
		stop_c;
		ok = ~|n;
	endtask

	task automatic rd(input logic [6:0] sa, input logic [7:0] ra, output logic [7:0] rv, output logic ok);
		logic [2:0] n;
		logic       last;
		#1.3;
		start_c;
		xbyte({sa, 1'b0}, rv, n[0]);
		xbyte(ra, rv, n[1]);
		start_c;
		xbyte({sa, 1'b1}, rv, n[2]);
		xbyte(8'hff, rv, last);
		stop_c;
		ok = ~|n;
	endtask
endmodule

/* verif/tb_top.sv */
/* Self-checking bench for the control register file.
   Assumes the master model drives scl and resolves sda. */
`timescale 1ns/100ps

module tb_top
	import otg_pkg::*;
;
	localparam int          CYC = 400;
	localparam logic [63:0] IDS     = 64'h8617_0eca_2468_ace0; // Arbitrary identity bytes
	localparam logic [7:0]  RSV [4]  = '{8'h08, 8'h12, 8'h17, 8'hff};
	localparam logic [7:0]  SUPV [4] = '{8'h18, 8'h04, 8'h10, 8'h00};
	logic       mclk;
	logic       sys_rst;
	logic       clk_en;
	logic       addr_strap;
	logic [6:0] stat;
	logic       scl;
	logic       sda_in;
	logic       sda_oe_n;
	logic       sda_out;
	logic       hnp;
	logic       irq_n_out;
	logic       irq_oe_n;
	logic [3:0] pulls;
	logic [2:0] sup;
	logic       pwr_dn;
	logic [6:0] sa;
	logic [7:0] rv;
	logic       ok;
	int         fail_count;
	int         n_tests;
	int         cnt;

	initial mclk = 1'b0;
	always #2 mclk = ~mclk;

	// Identity codes are arbitrary
	otg_regfile #(.CHG_CYC(CYC), .MAKER_CODE(IDS[31:0]), .PART_CODE(IDS[63:32])) u_dut (
		.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en),
		.scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_strap(addr_strap),
		.vbus_valid_in(stat[0]), .sess_valid_in(stat[1]), .sess_end_in(stat[2]), .id_gnd_in(stat[3]),
		.id_float_in(stat[4]), .a_hnp_in(stat[5]), .b_hnp_in(stat[6]),
		.irq_n_out(irq_n_out), .irq_oe_n(irq_oe_n),
		.pos_line_pull_high(pulls[0]), .neg_line_pull_high(pulls[1]),
		.pos_line_pull_low(pulls[2]), .neg_line_pull_low(pulls[3]), .hnp_connect_en(hnp),
		.power_down_ctl(pwr_dn), .charge_src_on(sup[0]), .pump_drive(sup[1]), .bleed_discharge(sup[2])
	);

	otg_i2c_master u_mst (.scl(scl), .sda_in(sda_in), .sda_oe_n(sda_oe_n));

	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wreg(input logic [7:0] ra, input logic [7:0] wd);
		@(posedge mclk);
		u_mst.wr(sa, ra, wd, ok);
		chk("write ack", {7'h0, ok}, 8'h01);
		repeat (12) @(posedge mclk);
	endtask

	task automatic rreg(input logic [7:0] ra, input logic [7:0] exp);
		@(posedge mclk);
		u_mst.rd(sa, ra, rv, ok);
		chk("read ack", {7'h0, ok}, 8'h01);
		chk("read data", rv, exp);
		repeat (12) @(posedge mclk);
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Hang guard
	initial begin
		repeat (100000) @(posedge mclk);
		fail_count++;
		summarize;
	end

	initial begin
		sys_rst = 1'b1;
		clk_en = 1'b1;
		addr_strap = 1'b0;
		stat = 7'h00;
		sa = 7'h2c;
		fail_count = 0;
		n_tests = 0;
		repeat (3) @(posedge mclk);
		sys_rst <= 1'b0;
		repeat (12) @(posedge mclk);
		chk("power down", {7'h0, pwr_dn}, 8'h01);
		chk("sda level", {7'h0, sda_out}, 8'h00);
		rreg(OFS_CTRL1, 8'h00);
		rreg(OFS_CTRL2, 8'h01);
		rreg(OFS_MASK, 8'h00);
		rreg(OFS_EDGE, 8'h00);
		rreg(OFS_LATCH, 8'h00);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			wreg(i[7:0], 8'hff);
			rreg(i[7:0], IDS[8 * i +: 8]);
		end
		foreach (RSV[k]) begin
			wreg(RSV[k], 8'hff);
			rreg(RSV[k], 8'h00);
		end
		$display("test id and reserved done");
		for (int b = 4; b < 8; b++) begin
			wreg(OFS_CTRL1, 8'h01 << b);
			chk("pulls", {4'h0, pulls}, 8'h01 << (b - 4));
		end
		wreg(OFS_CTRL1, 8'h30);
		chk("pull priority", {4'h0, pulls}, 8'h01);
		clk_en <= 1'b0;
		wreg(OFS_CTRL1, 8'h80);
		chk("frozen pulls", {4'h0, pulls}, 8'h01);
		clk_en <= 1'b1;
		repeat (8) @(posedge mclk);
		chk("thawed pulls", {4'h0, pulls}, 8'h08);
		wreg(OFS_CTRL1, 8'hff);
		rreg(OFS_CTRL1, 8'hf6);
		chk("hnp connect", {7'h0, hnp}, 8'h01);
		foreach (SUPV[k]) begin
			wreg(OFS_CTRL2, SUPV[k]);
			chk("supply paths", {5'h0, sup}, {5'h0, SUPV[k][4:2]});
			chk("shutdown", {7'h0, pwr_dn}, 8'h00);
		end
		wreg(OFS_CTRL2, 8'h04);
		repeat (CYC + 50) @(posedge mclk);
		chk("manual charge held", {7'h0, sup[0]}, 8'h01);
		wreg(OFS_CTRL2, 8'h00);
		for (int p = 0; p < 2; p++) begin
			wreg(OFS_CTRL2, 8'h02);
			chk("timed on", {7'h0, sup[0]}, 8'h01);
			cnt = 0;
			while (sup[0] === 1'b1 && cnt < 2 * CYC) begin
				@(posedge mclk);
				cnt++;
			end
			chk("timed length", {7'h0, cnt > CYC - 120 && cnt <= CYC}, 8'h01);
			wreg(OFS_CTRL2, 8'h02);
			chk("no retrigger", {7'h0, sup[0]}, 8'h00);
			wreg(OFS_CTRL2, 8'h00);
		end
		$display("test controls done");
		wreg(OFS_MASK, 8'hff);
		rreg(OFS_MASK, 8'h3f);
		wreg(OFS_MASK, 8'h00);
		wreg(OFS_EDGE, 8'hff);
		rreg(OFS_EDGE, 8'h03);
		wreg(OFS_CTRL1, 8'h00);
		stat <= 7'h01;
		repeat (10) @(posedge mclk);
		chk("irq masked", {7'h0, irq_oe_n}, 8'h01);
		wreg(OFS_MASK, 8'h01);
		chk("irq open drain", {6'h0, irq_oe_n, irq_n_out}, 8'h00);
		wreg(OFS_LATCH, 8'h00);
		rreg(OFS_LATCH, 8'h01);
		chk("irq released", {7'h0, irq_oe_n}, 8'h01);
		wreg(OFS_CTRL1, 8'h02);
		chk("irq push pull idle", {6'h0, irq_oe_n, irq_n_out}, 8'h01);
		wreg(OFS_EDGE, 8'h00);
		stat <= 7'h00;
		repeat (10) @(posedge mclk);
		chk("irq push pull low", {6'h0, irq_oe_n, irq_n_out}, 8'h00);
		rreg(OFS_LATCH, 8'h04);
		$display("test interrupts done");
		@(posedge mclk);
		u_mst.wr(7'h2d, OFS_MASK, 8'h00, ok);
		chk("foreign address", {7'h0, ok}, 8'h00);
		addr_strap <= 1'b1;
		sa = 7'h2d;
		wreg(OFS_MASK, 8'h21);
		rreg(OFS_MASK, 8'h21);
		$display("test address done");
		summarize;
	end
endmodule
